// ### src/ccu_cmp_channel.sv
// one comparator channel: pin sampling, halving divider, compare, edge event
`timescale 1ns/1ps
`default_nettype none
module ccu_cmp_channel #(
   parameter int VOLT_W = 8
) (
   input wire logic clock_in,               // peripheral clock
   input wire logic reset_n_in,             // async reset, active low
   input wire logic active_in,              // clocked, enabled, out of reset
   input wire logic [VOLT_W-1:0] voltage_in,   // monitored voltage code, async
   input wire logic [VOLT_W-1:0] reference_in, // reference code, same clock
   output logic result_out,                 // 1 while halved input above ref
   output logic rise_out                    // one-cycle pulse on result rise
);

   logic [VOLT_W-1:0] sync1_r;
   logic [VOLT_W-1:0] sync2_r;
   logic [VOLT_W-1:0] sync3_r;
   logic [VOLT_W-1:0] held_r;
   logic [VOLT_W-1:0] held_nxt;
   logic [VOLT_W-1:0] halved;
   logic result_r;
   logic result_nxt;
   logic rise_r;
   logic rise_nxt;

   // a multi-bit code may tear while changing: a code is taken only when
   // two samples past the synchroniser agree, else the last good one stays;
   // an input that changes on every clock is therefore never taken
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end
      else
      begin
         sync1_r <= voltage_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   always_comb
   begin
      held_nxt = held_r;
      if (sync2_r == sync3_r)
      begin
         held_nxt = sync2_r;
      end
      halved = held_nxt >> 1;
      result_nxt = 1'b0;
      if (active_in)
      begin
         result_nxt = (halved > reference_in);
      end
      rise_nxt = result_nxt & ~result_r;
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         held_r <= '0;
         result_r <= 1'b0;
         rise_r <= 1'b0;
      end
      else
      begin
         held_r <= held_nxt;
         result_r <= result_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign result_out = result_r;
   assign rise_out = rise_r;

endmodule
`default_nettype wire

// ### src/ccu_pkg.sv
// constants and types shared by the comparator control unit
package ccu_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int VOLT_W = 8;

   // register offsets
   localparam logic [3:0] OFS_CLOCK_GATE = 4'h0;
   localparam logic [3:0] OFS_MODE = 4'h1;
   localparam logic [3:0] OFS_IRQ_FLAGS = 4'h2;
   localparam logic [3:0] OFS_IRQ_MASKS = 4'h3;
   localparam logic [3:0] OFS_RESET_CTRL = 4'h4;
   localparam logic [3:0] OFS_RESULT = 4'h5;
   localparam logic [3:0] OFS_PIN_CFG = 4'h6;

   // field positions
   localparam int BIT_CLOCK_GATE = 5;
   localparam int BIT_CMP1_EN = 4;
   localparam int BIT_CMP0_EN = 0;
   localparam int BIT_CMP0_IRQ = 0;
   localparam int BIT_CMP1_IRQ = 1;
   localparam int BIT_BLOCK_RESET = 5;
   localparam int BIT_NEG_LOGIC = 0;

   // reset values
   localparam logic RST_CLOCK_GATE = 1'b0;
   localparam logic RST_CMP_EN = 1'b0;
   localparam logic [1:0] RST_IRQ_FLAGS = 2'h0;
   localparam logic [1:0] RST_IRQ_MASKS = 2'h3;
   localparam logic RST_BLOCK_RESET = 1'b1;
   localparam logic RST_NEG_LOGIC = 1'b1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ccu_bus_req_t;

   typedef struct packed {
      logic [VOLT_W-1:0] cmp1;
      logic [VOLT_W-1:0] cmp0;
   } ccu_volt_pair_t;

endpackage

// ### src/ccu_top.sv
// comparator control unit: registers, gating, interrupts and result pin
//
// What this block does
// - result is 1 when halved input above reference
// - negative-logic pin drives 0 when above
// - clock gate bit 5 stops or supplies clock
// - mode bit 4 enables comparator 1
// - mode bit 0 enables comparator 0
// - flag bits 0,1 show pending requests
// - mask bits 0,1 block matching request
// - reset bit 5 holds comparator in reset
// - halved input versus reference compared
`timescale 1ns/1ps
`default_nettype none
module ccu_top #(
   parameter int VOLT_W = ccu_pkg::VOLT_W
) (
   input wire logic clock_in,                       // 100 MHz clock
   input wire logic reset_n_in,                     // async reset, active low
   input wire ccu_pkg::ccu_bus_req_t bus_req_in,    // register request
   output logic [ccu_pkg::DATA_W-1:0] rd_data_out,  // read data, next cycle
   input wire ccu_pkg::ccu_volt_pair_t monitored_voltage_input_in, // pins
   input wire logic [VOLT_W-1:0] dac_reference_in,  // reference code
   output logic comparator_result_pin_out,          // result pin
   output logic irq_out                             // level interrupt
);

   // software state
   logic comparator_clock_gate_r;
   logic comparator_clock_gate_nxt;
   logic cmp1_run_enable_r;
   logic cmp1_run_enable_nxt;
   logic cmp0_run_enable_r;
   logic cmp0_run_enable_nxt;
   logic [1:0] irq_flags_r;
   logic [1:0] irq_flags_nxt;
   logic [1:0] irq_masks_r;
   logic [1:0] irq_masks_nxt;
   logic comparator_block_reset_r;
   logic comparator_block_reset_nxt;
   logic neg_logic_r;
   logic neg_logic_nxt;

   // bus answer
   logic [ccu_pkg::DATA_W-1:0] rd_data_r;
   logic [ccu_pkg::DATA_W-1:0] rd_data_nxt;

   // outputs
   logic pin_r;
   logic pin_nxt;
   logic irq_r;
   logic irq_nxt;

   // channel side
   logic cmp0_active;
   logic cmp1_active;
   logic cmp0_result;
   logic cmp1_result;
   logic cmp0_rise;
   logic cmp1_rise;
   logic [1:0] irq_events;
   logic [1:0] flag_clear;

   function automatic logic hit
   (
      input ccu_pkg::ccu_bus_req_t req,
      input logic [ccu_pkg::ADDR_W-1:0] ofs
   );
      hit = req.wr && (req.addr == ofs);
   endfunction

   function automatic logic rd_hit
   (
      input ccu_pkg::ccu_bus_req_t req,
      input logic [ccu_pkg::ADDR_W-1:0] ofs
   );
      rd_hit = req.rd && (req.addr == ofs);
   endfunction

   // a channel runs only when clocked, released from reset and enabled
   function automatic logic chan_active
   (
      input logic gate_on,
      input logic held_in_reset,
      input logic run_enable
   );
      chan_active = gate_on && !held_in_reset && run_enable;
   endfunction

   always_comb
   begin
      cmp0_active = chan_active(comparator_clock_gate_r,
         comparator_block_reset_r,
         cmp0_run_enable_r);
      cmp1_active = chan_active(comparator_clock_gate_r,
         comparator_block_reset_r,
         cmp1_run_enable_r);
   end

   ccu_cmp_channel #(
      .VOLT_W(VOLT_W)
   ) u_cmp0 (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .active_in(cmp0_active),
      .voltage_in(monitored_voltage_input_in.cmp0),
      .reference_in(dac_reference_in),
      .result_out(cmp0_result),
      .rise_out(cmp0_rise)
   );

   ccu_cmp_channel #(
      .VOLT_W(VOLT_W)
   ) u_cmp1 (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .active_in(cmp1_active),
      .voltage_in(monitored_voltage_input_in.cmp1),
      .reference_in(dac_reference_in),
      .result_out(cmp1_result),
      .rise_out(cmp1_rise)
   );

   // events are dropped as soon as a channel is held off, even mid-pulse
   always_comb
   begin
      irq_events = 2'h0;
      irq_events[ccu_pkg::BIT_CMP0_IRQ] = cmp0_rise && cmp0_active;
      irq_events[ccu_pkg::BIT_CMP1_IRQ] = cmp1_rise && cmp1_active;
   end

   // register writes
   always_comb
   begin
      comparator_clock_gate_nxt = comparator_clock_gate_r;
      cmp1_run_enable_nxt = cmp1_run_enable_r;
      cmp0_run_enable_nxt = cmp0_run_enable_r;
      irq_masks_nxt = irq_masks_r;
      comparator_block_reset_nxt = comparator_block_reset_r;
      neg_logic_nxt = neg_logic_r;
      flag_clear = 2'h0;
      if (hit(bus_req_in, ccu_pkg::OFS_CLOCK_GATE))
      begin
         comparator_clock_gate_nxt =
            bus_req_in.wdata[ccu_pkg::BIT_CLOCK_GATE];
      end
      else if (hit(bus_req_in, ccu_pkg::OFS_MODE))
      begin
         cmp1_run_enable_nxt = bus_req_in.wdata[ccu_pkg::BIT_CMP1_EN];
         cmp0_run_enable_nxt = bus_req_in.wdata[ccu_pkg::BIT_CMP0_EN];
      end
      else if (hit(bus_req_in, ccu_pkg::OFS_IRQ_FLAGS))
      begin
         flag_clear = bus_req_in.wdata[1:0];
      end
      else if (hit(bus_req_in, ccu_pkg::OFS_IRQ_MASKS))
      begin
         irq_masks_nxt = bus_req_in.wdata[1:0];
      end
      else if (hit(bus_req_in, ccu_pkg::OFS_RESET_CTRL))
      begin
         comparator_block_reset_nxt =
            bus_req_in.wdata[ccu_pkg::BIT_BLOCK_RESET];
      end
      else if (hit(bus_req_in, ccu_pkg::OFS_PIN_CFG))
      begin
         neg_logic_nxt = bus_req_in.wdata[ccu_pkg::BIT_NEG_LOGIC];
      end
      // a new request in the clearing cycle survives the clear
      irq_flags_nxt = (irq_flags_r & ~flag_clear) | irq_events;
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         comparator_clock_gate_r <= ccu_pkg::RST_CLOCK_GATE;
         cmp1_run_enable_r <= ccu_pkg::RST_CMP_EN;
         cmp0_run_enable_r <= ccu_pkg::RST_CMP_EN;
         irq_flags_r <= ccu_pkg::RST_IRQ_FLAGS;
         irq_masks_r <= ccu_pkg::RST_IRQ_MASKS;
         comparator_block_reset_r <= ccu_pkg::RST_BLOCK_RESET;
         neg_logic_r <= ccu_pkg::RST_NEG_LOGIC;
      end
      else
      begin
         comparator_clock_gate_r <= comparator_clock_gate_nxt;
         cmp1_run_enable_r <= cmp1_run_enable_nxt;
         cmp0_run_enable_r <= cmp0_run_enable_nxt;
         irq_flags_r <= irq_flags_nxt;
         irq_masks_r <= irq_masks_nxt;
         comparator_block_reset_r <= comparator_block_reset_nxt;
         neg_logic_r <= neg_logic_nxt;
      end
   end

   // register reads; unmapped offsets and unused bits read zero
   always_comb
   begin
      rd_data_nxt = 8'h00;
      if (rd_hit(bus_req_in, ccu_pkg::OFS_CLOCK_GATE))
      begin
         rd_data_nxt[ccu_pkg::BIT_CLOCK_GATE] = comparator_clock_gate_r;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_MODE))
      begin
         rd_data_nxt[ccu_pkg::BIT_CMP1_EN] = cmp1_run_enable_r;
         rd_data_nxt[ccu_pkg::BIT_CMP0_EN] = cmp0_run_enable_r;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_IRQ_FLAGS))
      begin
         rd_data_nxt[1:0] = irq_flags_r;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_IRQ_MASKS))
      begin
         rd_data_nxt[1:0] = irq_masks_r;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_RESET_CTRL))
      begin
         rd_data_nxt[ccu_pkg::BIT_BLOCK_RESET] = comparator_block_reset_r;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_RESULT))
      begin
         rd_data_nxt[ccu_pkg::BIT_CMP0_IRQ] = cmp0_result;
         rd_data_nxt[ccu_pkg::BIT_CMP1_IRQ] = cmp1_result;
      end
      else if (rd_hit(bus_req_in, ccu_pkg::OFS_PIN_CFG))
      begin
         rd_data_nxt[ccu_pkg::BIT_NEG_LOGIC] = neg_logic_r;
      end
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rd_data_r <= 8'h00;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // pin follows comparator 0; its result is already 0 while held off,
   // so the pin rests at the inactive level in either polarity
   always_comb
   begin
      if (neg_logic_r)
      begin
         pin_nxt = ~cmp0_result;
      end
      else
      begin
         pin_nxt = cmp0_result;
      end
      irq_nxt = |(irq_flags_r & ~irq_masks_r);
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pin_r <= 1'b1;
         irq_r <= 1'b0;
      end
      else
      begin
         pin_r <= pin_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign rd_data_out = rd_data_r;
   assign comparator_result_pin_out = pin_r;
   assign irq_out = irq_r;

endmodule
`default_nettype wire

// ### verif/ccu_env_model.sv
// far side: monitored voltage source and the led on the result pin
`timescale 1ns/1ps
`default_nettype none
module ccu_env_model (
   input wire logic clock_in, // clock
   input wire logic slow_in, // ramp channel 0 one code every other cycle
   input wire ccu_pkg::ccu_volt_pair_t target_in, // wanted voltages
   input wire logic pin_in, // result pin
   output ccu_pkg::ccu_volt_pair_t volt_out, // voltages at the pins
   output logic led_on_out // led lit
);
   ccu_pkg::ccu_volt_pair_t volt_nxt;
   logic step_r;
   initial volt_out = '0;
   initial step_r = 1'b0;
   // a converter code moves slower than the clock: one step every
   // other cycle, so each code stands for two samples
   always_comb
   begin
      volt_nxt = target_in;
      if (slow_in && volt_out.cmp0 < target_in.cmp0)
         volt_nxt.cmp0 = volt_out.cmp0 + {7'h00, step_r};
   end
   always @(posedge clock_in)
   begin
      volt_out <= volt_nxt;
      step_r <= !step_r;
   end
   // led sinks into the pin, so it lights on a low level
   assign led_on_out = !pin_in;
endmodule
`default_nettype wire

// ### verif/ccu_top_checker.sv
// port assertions for the comparator control unit
`timescale 1ns/1ps
`default_nettype none
module ccu_top_checker #(
   parameter int VOLT_W = 8
) (
   input wire logic clock_in, // clock
   input wire logic reset_n_in, // reset, active low
   input wire ccu_pkg::ccu_bus_req_t bus_req_in, // register request
   input wire logic [ccu_pkg::DATA_W-1:0] rd_data_out, // read data
   input wire ccu_pkg::ccu_volt_pair_t monitored_voltage_input_in, // pins
   input wire logic [VOLT_W-1:0] dac_reference_in, // reference
   input wire logic comparator_result_pin_out, // result pin
   input wire logic irq_out // interrupt
);
   logic [ccu_pkg::ADDR_W-1:0] a;
   logic r;
   logic [VOLT_W-1:0] v0;
   assign a = bus_req_in.addr;
   assign r = bus_req_in.rd;
   assign v0 = monitored_voltage_input_in.cmp0;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   property p_idle; !$past(r) |-> rd_data_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   property p_unmap; r && a > 4'h6 |=> rd_data_out == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_flg; r && a == 4'h2 |=> rd_data_out[7:2] == 6'h00; endproperty
   a_flg: assert property (p_flg) else $error("flag spare bits");
   property p_mode; r && a == 4'h1 |=> (rd_data_out & 8'hEE) == 8'h00;
   endproperty
   a_mode: assert property (p_mode) else $error("mode spare bits");
   property p_gate; r && a == 4'h0 |=> (rd_data_out & 8'hDF) == 8'h00;
   endproperty
   a_gate: assert property (p_gate) else $error("gate spare bits");
   property p_rst; r && a == 4'h4 |=> (rd_data_out & 8'hDF) == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset spare bits");
   // masks applied take two edges: mask register, then interrupt flop
   property p_mask;
      bus_req_in.wr && a == 4'h3 && bus_req_in.wdata[1:0] == 2'h3
         |-> ##2 !irq_out;
   endproperty
   a_mask: assert property (p_mask) else $error("masked irq high");
   // strict compare: halved input equal to the reference is not above
   property p_below;
      ($stable(v0) && $stable(dac_reference_in))[*4]
         ##0 (r && a == 4'h5 && (v0 >> 1) <= dac_reference_in)
         |=> !rd_data_out[0];
   endproperty
   a_below: assert property (p_below) else $error("result above");
   c_irq: cover property ($rose(irq_out));
   c_led: cover property ($fell(comparator_result_pin_out));
   c_unmap: cover property (r && a > 4'h6);
endmodule
bind ccu_top ccu_top_checker #(.VOLT_W(VOLT_W)) chk_u (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .bus_req_in(bus_req_in),
   .rd_data_out(rd_data_out),
   .monitored_voltage_input_in(monitored_voltage_input_in),
   .dac_reference_in(dac_reference_in),
   .comparator_result_pin_out(comparator_result_pin_out),
   .irq_out(irq_out));
`default_nettype wire

// ### verif/tb_top.sv
// testbench for the comparator control unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock_in;
   logic reset_n_in;
   logic slow;
   logic led;
   logic pin;
   logic irq;
   logic [7:0] rdata;
   logic [7:0] dac;
   ccu_pkg::ccu_bus_req_t req;
   ccu_pkg::ccu_volt_pair_t tgt;
   ccu_pkg::ccu_volt_pair_t volt;
   int num_errors;
   int checked;
   ccu_top dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .bus_req_in(req), .rd_data_out(rdata),
      .monitored_voltage_input_in(volt), .dac_reference_in(dac),
      .comparator_result_pin_out(pin), .irq_out(irq));
   ccu_env_model env_u (.clock_in(clock_in), .slow_in(slow),
      .target_in(tgt), .pin_in(pin), .volt_out(volt), .led_on_out(led));
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_in);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_in);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_in);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_in);
      req.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic wait_led(input logic e, input int lim);
      int n;
      n = 0;
      while (led !== e && n < lim)
      begin
         cyc(1);
         n++;
      end
      chk_bit(led, e);
      if (led !== e)
         final_report();
   endtask
   task automatic t_reset_vals;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h03);
      rd(4'h4, 8'h20);
      rd(4'hF, 8'h00);
      chk_bit(pin, 1'b1);
   endtask
   task automatic t_setup;
      wr(4'h2, 8'h03);
      wr(4'h3, 8'h03);
      wr(4'h0, 8'hFF);
      wr(4'h4, 8'h00);
      wr(4'h1, 8'hFF);
      rd(4'h0, 8'h20);
      rd(4'h1, 8'h11);
   endtask
   task automatic t_compare;
      @(posedge clock_in);
      tgt <= '{cmp1: 8'h00, cmp0: 8'h80};
      cyc(8);
      rd(4'h5, 8'h00);
      @(posedge clock_in);
      tgt <= '{cmp1: 8'h90, cmp0: 8'h82};
      wait_led(1'b1, 20);
      rd(4'h5, 8'h03);
      rd(4'h2, 8'h03);
      chk_bit(irq, 1'b0);
      wr(4'h3, 8'h02);
      cyc(2);
      chk_bit(irq, 1'b1);
      wr(4'h2, 8'h01);
      cyc(2);
      chk_bit(irq, 1'b0);
      rd(4'h2, 8'h02);
      wr(4'h3, 8'h03);
   endtask
   task automatic t_hold_off;
      logic [3:0] a [3] = '{4'h1, 4'h4, 4'h0};
      logic [7:0] off [3] = '{8'h00, 8'h20, 8'h00};
      logic [7:0] on [3] = '{8'h11, 8'h00, 8'h20};
      for (int i = 0; i < 3; i++)
      begin
         wr(a[i], off[i]);
         cyc(4);
         chk_bit(pin, 1'b1);
         rd(4'h5, 8'h00);
         wr(4'h2, 8'h03);
         rd(4'h2, 8'h00);
         wr(a[i], on[i]);
         cyc(6);
         rd(4'h5, 8'h03);
      end
      wr(4'h1, 8'h01);
      cyc(6);
      rd(4'h5, 8'h01);
      wr(4'h1, 8'h10);
      cyc(6);
      rd(4'h5, 8'h02);
      wr(4'h1, 8'h11);
   endtask
   task automatic t_pin_mode;
      rd(4'h6, 8'h01);
      wr(4'h3, 8'h01);
      cyc(2);
      chk_bit(irq, 1'b1);
      wr(4'h2, 8'h02);
      cyc(2);
      chk_bit(irq, 1'b0);
      wr(4'h3, 8'h03);
      wr(4'h6, 8'h00);
      rd(4'h6, 8'h00);
      chk_bit(pin, 1'b1);
      wr(4'h1, 8'h10);
      cyc(4);
      chk_bit(pin, 1'b0);
      wr(4'h1, 8'h11);
      wr(4'h6, 8'h01);
   endtask
   task automatic t_slow;
      @(posedge clock_in);
      tgt <= '{cmp1: 8'h00, cmp0: 8'h70};
      wait_led(1'b0, 20);
      @(posedge clock_in);
      slow <= 1'b1;
      tgt <= '{cmp1: 8'h00, cmp0: 8'h90};
      wait_led(1'b1, 80);
   endtask
   initial
   begin
      num_errors = 0;
      checked = 0;
      reset_n_in = 1'b0;
      slow = 1'b0;
      req = '0;
      dac = 8'h40;
      tgt = '0;
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      t_reset_vals();
      t_setup();
      t_compare();
      t_hold_off();
      t_pin_mode();
      t_slow();
      final_report();
   end
endmodule
`default_nettype wire
